// File: dv/pfs_host_model.sv
// Purpose: host side of the register port
// Assumes: slave never stalls, read data one cycle later
// Notes: tasks are called from the testbench
`timescale 1ns/100ps
module pfs_host_model
    import pfs_pkg::*;
(
    input wire logic clk_i,
    input wire logic [DATA_W-1:0] rdata_i,
    output logic [ADDR_W-1:0] addr_o,
    output logic [DATA_W-1:0] wdata_o,
    output logic wr_o,
    output logic rd_o
);
    initial
    begin
        addr_o = 4'h0;
        wdata_o = 32'h0;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
    endtask
    // status read back to learn the fault cause
    task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        #1 d = rdata_i;
    endtask
endmodule

// File: dv/pfs_monitor.sv
// Purpose: port checker for the power fault supervisor
// Assumes: comparator filter settles within 5 edges
// Notes: bound to the top module at the foot of this file
`timescale 1ns/100ps
module pfs_monitor
    import pfs_pkg::*;
#(
    parameter int RESTART_CYCLES = RESTART_CYC,
    parameter int BOOST_OC_CYCLES = BOOST_OC_CYC,
    parameter int SOFTSTART_CYCLES = SOFTSTART_CYC
)(
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic input_low_sense_pin_i,
    input wire logic input_voltage_sense_pin_i,
    input wire logic supply_low_i,
    input wire logic input_current_shunt_i,
    input wire logic feedback_pin_over_low_i,
    input wire logic boost_current_limit_i,
    input wire logic rd_i,
    input wire logic [DATA_W-1:0] rdata_o,
    input wire logic boost_en_o,
    input wire logic boost_switch_en_o,
    input wire logic led_en_o,
    input wire logic power_switch_en_o,
    input wire logic pump_en_o,
    input wire logic irq_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!arst_n_i);
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_led_chain: assert property (led_en_o |-> boost_en_o && power_switch_en_o && pump_en_o)
        else $error("led outputs on without boost");
    a_switch_gate: assert property (boost_switch_en_o |-> boost_en_o)
        else $error("switching without boost enabled");
    a_uv_standby: assert property (input_low_sense_pin_i [*8] |-> !boost_en_o && !led_en_o && !power_switch_en_o)
        else $error("outputs on during input undervoltage");
    a_ov_standby: assert property (input_voltage_sense_pin_i [*8] |-> !boost_en_o && !led_en_o && !power_switch_en_o)
        else $error("outputs on during input overvoltage");
    a_vdd_standby: assert property (supply_low_i [*8] |-> !boost_en_o && !led_en_o && !power_switch_en_o)
        else $error("outputs on during supply undervoltage");
    a_oc_shut: assert property (input_current_shunt_i [*8] |-> !boost_en_o && !led_en_o)
        else $error("outputs on during input overcurrent");
    a_clim_gate: assert property (boost_current_limit_i [*8] |-> !boost_switch_en_o)
        else $error("switching during current limit");
    a_ovl_gate: assert property (feedback_pin_over_low_i [*8] |-> !boost_switch_en_o)
        else $error("switching during feedback overvoltage");
    a_read_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
        else $error("read data outside read cycle");
    a_soft_first: assert property ($rose(boost_en_o) |-> !led_en_o [*4])
        else $error("led outputs before soft start ends");
    c_irq: cover property (irq_o ##1 !irq_o);
    c_led_off: cover property ($fell(led_en_o));
    c_led_on: cover property ($rose(led_en_o));
endmodule

bind pfs_power_fault_supervisor pfs_monitor #(.RESTART_CYCLES(RESTART_CYCLES),
    .BOOST_OC_CYCLES(BOOST_OC_CYCLES), .SOFTSTART_CYCLES(SOFTSTART_CYCLES)) pfs_monitor_i (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .input_low_sense_pin_i(input_low_sense_pin_i),
    .input_voltage_sense_pin_i(input_voltage_sense_pin_i), .supply_low_i(supply_low_i),
    .input_current_shunt_i(input_current_shunt_i), .feedback_pin_over_low_i(feedback_pin_over_low_i),
    .boost_current_limit_i(boost_current_limit_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .boost_en_o(boost_en_o), .boost_switch_en_o(boost_switch_en_o), .led_en_o(led_en_o),
    .power_switch_en_o(power_switch_en_o), .pump_en_o(pump_en_o), .irq_o(irq_o));

// File: dv/pfs_tb.sv
// Purpose: self-checking bench for the power fault supervisor
// Assumes: short timer parameters 40, 50, 8
// Notes: comparator pins driven from one vector
`timescale 1ns/100ps
module testbench;
    import pfs_pkg::*;
    localparam int RST_C = 40;
    localparam int OC_C = 50;
    localparam int SS_C = 8;
    logic clk_i, arst_n_i, led_f, cfg_f;
    logic [NIN-1:0] cmp;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata;
    logic wr, rd, bst, sw, led, pwr, pmp, irq;
    int fail_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    pfs_power_fault_supervisor #(.RESTART_CYCLES(RST_C), .BOOST_OC_CYCLES(OC_C), .SOFTSTART_CYCLES(SS_C))
    pfs_power_fault_supervisor_i (.clk_i(clk_i), .arst_n_i(arst_n_i),
        .input_low_sense_pin_i(cmp[IN_LOW]), .input_voltage_sense_pin_i(cmp[IN_HIGH]),
        .supply_low_i(cmp[IN_VDD_LOW]), .input_current_shunt_i(cmp[IN_OC]), .pump_output_pin_i(cmp[IN_PUMP_LOW]),
        .pump_capacitor_fault_i(cmp[IN_PUMP_CAP]), .config_check_fail_i(cfg_f),
        .feedback_pin_over_low_i(cmp[IN_FB_OVL]), .feedback_pin_over_high_i(cmp[IN_FB_OVH]),
        .output_bleed_pin_i(cmp[IN_BLEED]), .feedback_pin_under_i(cmp[IN_FB_UV]),
        .boost_current_limit_i(cmp[IN_CLIM]), .led_fault_i(led_f), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .boost_en_o(bst), .boost_switch_en_o(sw), .led_en_o(led),
        .power_switch_en_o(pwr), .pump_en_o(pmp), .irq_o(irq));
    pfs_host_model host_i (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
    initial
    begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            fail_count++;
            final_report();
        end
    end
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(string n, logic [31:0] s, logic [31:0] e);
        cmp_count++;
        if (s !== e)
        begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic rdc(logic [ADDR_W-1:0] a, logic [31:0] e);
        logic [31:0] v;
        host_i.rd_reg(a, v);
        chk($sformatf("reg %0d", a), v, e);
    endtask
    task automatic pin(int p, logic v, int n);
        @(posedge clk_i);
        cmp[p] <= v;
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_init();
        repeat (20) @(posedge clk_i);
        rdc(STATE_ADDR, 32'h2);
        rdc(SUPPLY_STATUS_ADDR, 32'h40);
        chk("irq", irq, 1'b1);
        rdc(SUPPLY_MASK_ADDR, 32'h7f);
        rdc(BOOST_MASK_ADDR, 32'h7);
        rdc(LED_MASK_ADDR, 32'h1);
        host_i.wr_reg(BOOST_MASK_ADDR, 32'h5);
        rdc(BOOST_MASK_ADDR, 32'h5);
        host_i.wr_reg(SUPPLY_STATUS_ADDR, 32'h40);
        host_i.wr_reg(STATE_ADDR, 32'h0);
        host_i.wr_reg(4'h7, 32'hff);
        rdc(SUPPLY_STATUS_ADDR, 32'h0);
        rdc(STATE_ADDR, 32'h2);
        rdc(4'h7, 32'h0);
        chk("irq", irq, 1'b0);
        $display("test init done");
    endtask
    task automatic t_standby(int p, int b);
        pin(p, 1'b1, 8);
        chk("outs", {bst, pwr, led, pmp}, 4'h0);
        chk("irq", irq, 1'b1);
        rdc(STATE_ADDR, 32'h3);
        rdc(SUPPLY_STATUS_ADDR, 32'h1 << b);
        pin(p, 1'b0, SS_C + 10);
        rdc(STATE_ADDR, 32'h2);
        chk("outs", {bst, sw, pwr, led, pmp}, 5'h1f);
        host_i.wr_reg(SUPPLY_STATUS_ADDR, 32'h1 << b);
        rdc(SUPPLY_STATUS_ADDR, 32'h0);
        $display("test standby %0d done", p);
    endtask
    task automatic t_mask();
        host_i.wr_reg(SUPPLY_MASK_ADDR, 32'h0);
        pin(IN_LOW, 1'b1, 8);
        chk("irq", irq, 1'b0);
        host_i.wr_reg(SUPPLY_MASK_ADDR, 32'h7f);
        #1 chk("irq", irq, 1'b1);
        pin(IN_LOW, 1'b0, SS_C + 10);
        host_i.wr_reg(SUPPLY_STATUS_ADDR, 32'h1);
        led_f <= 1'b1;
        pin(IN_LOW, 1'b0, 6);
        rdc(LED_STATUS_ADDR, 32'h1);
        @(posedge clk_i) led_f <= 1'b0;
        host_i.wr_reg(LED_STATUS_ADDR, 32'h1);
        #1 chk("irq", irq, 1'b0);
        $display("test mask done");
    endtask
    task automatic t_recovery(int p, logic [ADDR_W-1:0] a, int b);
        pin(p, 1'b1, 8);
        chk("outs", {bst, pwr, led, pmp}, 4'h0);
        rdc(STATE_ADDR, 32'h4);
        rdc(a, 32'h1 << b);
        pin(p, 1'b0, RST_C - 20);
        rdc(STATE_ADDR, 32'h4);
        pin(p, 1'b0, RST_C);
        rdc(STATE_ADDR, 32'h2);
        host_i.wr_reg(a, 32'h1 << b);
        $display("test recovery %0d done", p);
    endtask
    task automatic t_gate();
        pin(IN_CLIM, 1'b1, 8);
        chk("switch", sw, 1'b0);
        rdc(STATE_ADDR, 32'h2);
        rdc(BOOST_STATUS_ADDR, 32'h0);
        chk("irq", irq, 1'b0);
        pin(IN_CLIM, 1'b0, 8);
        pin(IN_FB_OVL, 1'b1, 8);
        chk("switch", sw, 1'b0);
        host_i.wr_reg(BOOST_STATUS_ADDR, 32'h1);
        rdc(BOOST_STATUS_ADDR, 32'h1);
        rdc(STATE_ADDR, 32'h2);
        pin(IN_FB_OVL, 1'b0, 8);
        host_i.wr_reg(BOOST_STATUS_ADDR, 32'h1);
        rdc(BOOST_STATUS_ADDR, 32'h0);
        chk("switch", sw, 1'b1);
        $display("test gating done");
    endtask
    task automatic t_boost_oc();
        pin(IN_FB_UV, 1'b1, OC_C - 20);
        pin(IN_FB_UV, 1'b0, 8);
        rdc(BOOST_STATUS_ADDR, 32'h0);
        pin(IN_FB_UV, 1'b1, OC_C + 8);
        rdc(BOOST_STATUS_ADDR, 32'h4);
        rdc(STATE_ADDR, 32'h4);
        pin(IN_FB_UV, 1'b0, RST_C + SS_C + 10);
        rdc(STATE_ADDR, 32'h2);
        host_i.wr_reg(BOOST_STATUS_ADDR, 32'h4);
        $display("test boost overcurrent done");
    endtask
    task automatic t_pump_cap();
        cmp[IN_PUMP_CAP] <= 1'b1;
        pin(IN_OC, 1'b1, 8);
        pin(IN_OC, 1'b0, RST_C + 6);
        rdc(SUPPLY_STATUS_ADDR, 32'h38);
        rdc(STATE_ADDR, 32'h4);
        pin(IN_PUMP_CAP, 1'b0, RST_C + SS_C + 10);
        rdc(STATE_ADDR, 32'h2);
        host_i.wr_reg(SUPPLY_STATUS_ADDR, 32'h38);
        $display("test pump capacitor done");
    endtask
    initial
    begin
        cmp = '0;
        led_f = 1'b0;
        cfg_f = 1'b1;
        arst_n_i = 1'b0;
        repeat (2) @(posedge clk_i);
        arst_n_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        cfg_f <= 1'b0;
        t_init();
        t_standby(IN_LOW, SUP_IN_UV);
        t_standby(IN_HIGH, SUP_IN_OV);
        t_standby(IN_VDD_LOW, SUP_VDD_UV);
        t_mask();
        t_recovery(IN_OC, SUPPLY_STATUS_ADDR, SUP_IN_OC);
        t_recovery(IN_PUMP_LOW, SUPPLY_STATUS_ADDR, SUP_PUMP_LOW);
        t_recovery(IN_FB_OVH, BOOST_STATUS_ADDR, BST_OV_HIGH);
        t_recovery(IN_BLEED, BOOST_STATUS_ADDR, BST_OV_HIGH);
        t_gate();
        t_boost_oc();
        t_pump_cap();
        final_report();
    end
endmodule

// File: rtl/pfs_pkg.sv
// Purpose: constants shared by the power fault supervisor
// Assumes: 40 MHz core clock
// Notes: register indices are word addresses on the plain register port
package pfs_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int CLK_KHZ = 40000;
    localparam int RESTART_MS = 100;
    localparam int BOOST_OC_MS = 110;
    localparam int RESTART_CYC = RESTART_MS * CLK_KHZ;
    localparam int BOOST_OC_CYC = BOOST_OC_MS * CLK_KHZ;
    localparam int SOFTSTART_CYC = 64;
    localparam int CNT_W = 23;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] SUPPLY_STATUS_ADDR = 4'h0;
    localparam logic [ADDR_W-1:0] BOOST_STATUS_ADDR = 4'h1;
    localparam logic [ADDR_W-1:0] LED_STATUS_ADDR = 4'h2;
    localparam logic [ADDR_W-1:0] SUPPLY_MASK_ADDR = 4'h3;
    localparam logic [ADDR_W-1:0] BOOST_MASK_ADDR = 4'h4;
    localparam logic [ADDR_W-1:0] LED_MASK_ADDR = 4'h5;
    localparam logic [ADDR_W-1:0] STATE_ADDR = 4'h6;

    // supply status fields
    localparam int SUP_W = 7;
    localparam int SUP_IN_UV = 0;
    localparam int SUP_IN_OV = 1;
    localparam int SUP_VDD_UV = 2;
    localparam int SUP_IN_OC = 3;
    localparam int SUP_PUMP_LOW = 4;
    localparam int SUP_PUMP_CAP = 5;
    localparam int SUP_CFG_ERR = 6;
    // boost status fields
    localparam int BST_W = 3;
    localparam int BST_OV_LOW = 0;
    localparam int BST_OV_HIGH = 1;
    localparam int BST_OC = 2;
    // led status fields
    localparam int LED_W = 1;
    localparam int LED_ANY = 0;

    localparam logic [SUP_W-1:0] SUP_MASK_RST = 7'h7f;
    localparam logic [BST_W-1:0] BST_MASK_RST = 3'h7;
    localparam logic [LED_W-1:0] LED_MASK_RST = 1'h1;

    // ------------------------------------------------------------
    // comparator input vector positions
    // ------------------------------------------------------------
    localparam int NIN = 11;
    localparam int IN_LOW = 0;
    localparam int IN_HIGH = 1;
    localparam int IN_VDD_LOW = 2;
    localparam int IN_OC = 3;
    localparam int IN_PUMP_LOW = 4;
    localparam int IN_PUMP_CAP = 5;
    localparam int IN_FB_OVL = 6;
    localparam int IN_FB_OVH = 7;
    localparam int IN_BLEED = 8;
    localparam int IN_FB_UV = 9;
    localparam int IN_CLIM = 10;

    typedef enum logic [2:0] {
        PFS_INIT = 3'b000,
        PFS_SOFTSTART = 3'b001,
        PFS_NORMAL = 3'b010,
        PFS_STANDBY = 3'b011,
        PFS_RECOVERY = 3'b100
    } pfs_state_t;

endpackage

// File: rtl/pfs_power_fault_supervisor.sv
// Purpose: fault supervisor for a boost led driver
// Assumes: comparator results arrive asynchronously, high = condition present
// Notes: one clock domain, plain register port with one cycle read latency
//
// Overview of operation
// - input undervoltage: shut down, standby, flag, interrupt
// - leave undervoltage standby when input recovers
// - input overvoltage: shut down, standby, flag, interrupt
// - leave overvoltage standby when input falls back
// - supply undervoltage: standby, flag, auto return
// - input overcurrent: recovery, flag, retry 100 ms
// - current limit only gates switching, nothing else
// - pump low: recovery, flag, retry 100 ms
// - pump capacitor fault at init sets two flags
// - config check error: flag only, keep running
// - feedback overvoltage low stops switching, no recovery
// - overvoltage high or bleed: flag, recovery, retry
// - feedback under for 110 ms: flag, recovery
// - overcurrent timer runs while feedback is under during boost
// - persistent condition sets flag again after clear, except the edge-set led fault and the config error sampled in init only
// - separate supply, boost and led status registers
//
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
module pfs_power_fault_supervisor
    import pfs_pkg::*;
#(
    parameter int RESTART_CYCLES = RESTART_CYC,
    parameter int BOOST_OC_CYCLES = BOOST_OC_CYC,
    parameter int SOFTSTART_CYCLES = SOFTSTART_CYC
)(
    input wire logic clk_i,
    input wire logic arst_n_i,
    // comparator results
    input wire logic input_low_sense_pin_i,
    input wire logic input_voltage_sense_pin_i,
    input wire logic supply_low_i,
    input wire logic input_current_shunt_i,
    input wire logic pump_output_pin_i,
    input wire logic pump_capacitor_fault_i,
    input wire logic config_check_fail_i,
    input wire logic feedback_pin_over_low_i,
    input wire logic feedback_pin_over_high_i,
    input wire logic output_bleed_pin_i,
    input wire logic feedback_pin_under_i,
    input wire logic boost_current_limit_i,
    input wire logic led_fault_i,
    // register port
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [DATA_W-1:0] rdata_o,
    // power controls
    output logic boost_en_o,
    output logic boost_switch_en_o,
    output logic led_en_o,
    output logic power_switch_en_o,
    output logic pump_en_o,
    output logic irq_o
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // sticky flag update: hardware set beats software write-one clear
    function automatic logic [7:0] w1c_update(input logic [7:0] cur, input logic [7:0] set,
                                              input logic hit, input logic [7:0] clr);
        logic [7:0] keep;
        keep = hit ? (cur & ~clr) : cur;
        return keep | set;
    endfunction

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    // top bit carries the led fault input
    logic [NIN:0] raw;
    logic [NIN:0] sync1_reg;
    logic [NIN:0] sync2_reg;
    logic [NIN:0] sync3_reg;
    logic [NIN:0] filt_reg;

    assign raw[IN_LOW] = input_low_sense_pin_i;
    assign raw[IN_HIGH] = input_voltage_sense_pin_i;
    assign raw[IN_VDD_LOW] = supply_low_i;
    assign raw[IN_OC] = input_current_shunt_i;
    assign raw[IN_PUMP_LOW] = pump_output_pin_i;
    assign raw[IN_PUMP_CAP] = pump_capacitor_fault_i;
    assign raw[IN_FB_OVL] = feedback_pin_over_low_i;
    assign raw[IN_FB_OVH] = feedback_pin_over_high_i;
    assign raw[IN_BLEED] = output_bleed_pin_i;
    assign raw[IN_FB_UV] = feedback_pin_under_i;
    assign raw[IN_CLIM] = boost_current_limit_i;
    assign raw[NIN] = led_fault_i;

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            sync3_reg <= '0;
        end
        else
        begin
            sync1_reg <= raw;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    // a change counts once stages two and three agree
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            filt_reg <= '0;
        end
        else
        begin
            for (int i = 0; i <= NIN; i++)
            begin
                if (sync2_reg[i] == sync3_reg[i])
                    filt_reg[i] <= sync3_reg[i];
            end
        end
    end

    logic led_prev_reg;
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            led_prev_reg <= 1'b0;
        end
        else
        begin
            led_prev_reg <= filt_reg[NIN];
        end
    end

    // ------------------------------------------------------------
    // fault classification
    // ------------------------------------------------------------
    pfs_state_t state_reg;
    pfs_state_t state_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] oc_cnt_reg;
    logic running;
    logic boosting;
    logic in_init;
    logic standby_cause;
    logic recovery_cause;
    logic ovh_cause;
    logic oc_expired;
    logic cap_fault;

    assign in_init = (state_reg == PFS_INIT);
    assign boosting = (state_reg == PFS_SOFTSTART) || (state_reg == PFS_NORMAL);
    assign running = in_init || boosting;
    assign standby_cause = filt_reg[IN_LOW] | filt_reg[IN_HIGH] | filt_reg[IN_VDD_LOW];
    assign ovh_cause = boosting && (filt_reg[IN_FB_OVH] | filt_reg[IN_BLEED]);
    assign oc_expired = boosting && filt_reg[IN_FB_UV]
                        && (oc_cnt_reg >= CNT_W'(BOOST_OC_CYCLES - 1));
    assign cap_fault = in_init && filt_reg[IN_PUMP_CAP];
    assign recovery_cause = running && (filt_reg[IN_OC] | filt_reg[IN_PUMP_LOW] | cap_fault
                            | ovh_cause | oc_expired);

    // ------------------------------------------------------------
    // operating state
    // ------------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            PFS_INIT, PFS_SOFTSTART, PFS_NORMAL:
            begin
                if (recovery_cause)
                    state_next = PFS_RECOVERY;
                else if (standby_cause)
                    state_next = PFS_STANDBY;
                else if (in_init)
                    state_next = PFS_SOFTSTART;
                else if (state_reg == PFS_SOFTSTART && cnt_reg >= CNT_W'(SOFTSTART_CYCLES - 1))
                    state_next = PFS_NORMAL;
            end
            PFS_STANDBY:
                if (!standby_cause)
                    state_next = PFS_INIT;
            PFS_RECOVERY:
                if (cnt_reg >= CNT_W'(RESTART_CYCLES - 1))
                    state_next = PFS_INIT;
            default: state_next = PFS_INIT;
        endcase
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            state_reg <= PFS_INIT;
        else
            state_reg <= state_next;
    end

    // shared counter for soft-start and restart delay
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            cnt_reg <= '0;
        else if (state_next != state_reg)
            cnt_reg <= '0;
        else
            cnt_reg <= cnt_reg + CNT_W'(1);
    end

    // boost overcurrent timer, cancelled when feedback recovers
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            oc_cnt_reg <= '0;
        end
        else if (boosting && filt_reg[IN_FB_UV] && !oc_expired)
        begin
            oc_cnt_reg <= oc_cnt_reg + CNT_W'(1);
        end
        else
        begin
            oc_cnt_reg <= '0;
        end
    end

    // ------------------------------------------------------------
    // power controls
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            boost_en_o <= 1'b0;
            boost_switch_en_o <= 1'b0;
            led_en_o <= 1'b0;
            power_switch_en_o <= 1'b0;
            pump_en_o <= 1'b0;
        end
        else
        begin
            boost_en_o <= (state_next == PFS_SOFTSTART) || (state_next == PFS_NORMAL);
            boost_switch_en_o <= ((state_next == PFS_SOFTSTART) || (state_next == PFS_NORMAL))
                                 && !filt_reg[IN_FB_OVL] && !filt_reg[IN_CLIM];
            led_en_o <= (state_next == PFS_NORMAL);
            power_switch_en_o <= (state_next == PFS_SOFTSTART) || (state_next == PFS_NORMAL);
            pump_en_o <= (state_next != PFS_RECOVERY) && (state_next != PFS_STANDBY);
        end
    end

    // ------------------------------------------------------------
    // status and mask registers
    // ------------------------------------------------------------
    logic [SUP_W-1:0] sup_status_reg;
    logic [BST_W-1:0] bst_status_reg;
    logic [LED_W-1:0] led_status_reg;
    logic [SUP_W-1:0] sup_mask_reg;
    logic [BST_W-1:0] bst_mask_reg;
    logic [LED_W-1:0] led_mask_reg;
    logic [SUP_W-1:0] sup_set;
    logic [BST_W-1:0] bst_set;
    logic [LED_W-1:0] led_set;
    logic [7:0] sup_upd;
    logic [7:0] bst_upd;
    logic [7:0] led_upd;

    always_comb
    begin
        sup_set = '0;
        sup_set[SUP_IN_UV] = filt_reg[IN_LOW];
        sup_set[SUP_IN_OV] = filt_reg[IN_HIGH];
        sup_set[SUP_VDD_UV] = filt_reg[IN_VDD_LOW];
        sup_set[SUP_IN_OC] = running && filt_reg[IN_OC];
        sup_set[SUP_PUMP_LOW] = (running && filt_reg[IN_PUMP_LOW]) || cap_fault;
        sup_set[SUP_PUMP_CAP] = cap_fault;
        sup_set[SUP_CFG_ERR] = in_init && config_check_fail_i;
        bst_set = '0;
        bst_set[BST_OV_LOW] = boosting && filt_reg[IN_FB_OVL];
        bst_set[BST_OV_HIGH] = ovh_cause;
        bst_set[BST_OC] = oc_expired;
        led_set = '0;
        led_set[LED_ANY] = filt_reg[NIN] && !led_prev_reg;
    end

    assign sup_upd = w1c_update(8'(sup_status_reg), 8'(sup_set),
                                wr_i && addr_i == SUPPLY_STATUS_ADDR, wdata_i[7:0]);
    assign bst_upd = w1c_update(8'(bst_status_reg), 8'(bst_set),
                                wr_i && addr_i == BOOST_STATUS_ADDR, wdata_i[7:0]);
    assign led_upd = w1c_update(8'(led_status_reg), 8'(led_set),
                                wr_i && addr_i == LED_STATUS_ADDR, wdata_i[7:0]);

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            sup_status_reg <= '0;
            bst_status_reg <= '0;
            led_status_reg <= '0;
        end
        else
        begin
            sup_status_reg <= sup_upd[SUP_W-1:0];
            bst_status_reg <= bst_upd[BST_W-1:0];
            led_status_reg <= led_upd[LED_W-1:0];
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            sup_mask_reg <= SUP_MASK_RST;
            bst_mask_reg <= BST_MASK_RST;
            led_mask_reg <= LED_MASK_RST;
        end
        else if (wr_i)
        begin
            if (addr_i == SUPPLY_MASK_ADDR)
                sup_mask_reg <= wdata_i[SUP_W-1:0];
            if (addr_i == BOOST_MASK_ADDR)
                bst_mask_reg <= wdata_i[BST_W-1:0];
            if (addr_i == LED_MASK_ADDR)
                led_mask_reg <= wdata_i[LED_W-1:0];
        end
    end

    // level interrupt from any enabled sticky flag
    assign irq_o = |(sup_status_reg & sup_mask_reg) | |(bst_status_reg & bst_mask_reg)
                   | |(led_status_reg & led_mask_reg);

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            rdata_o <= '0;
        end
        else if (rd_i)
        begin
            unique case (addr_i)
                SUPPLY_STATUS_ADDR: rdata_o <= DATA_W'(sup_status_reg);
                BOOST_STATUS_ADDR: rdata_o <= DATA_W'(bst_status_reg);
                LED_STATUS_ADDR: rdata_o <= DATA_W'(led_status_reg);
                SUPPLY_MASK_ADDR: rdata_o <= DATA_W'(sup_mask_reg);
                BOOST_MASK_ADDR: rdata_o <= DATA_W'(bst_mask_reg);
                LED_MASK_ADDR: rdata_o <= DATA_W'(led_mask_reg);
                STATE_ADDR: rdata_o <= DATA_W'(state_reg);
                default: rdata_o <= '0;
            endcase
        end
        else
        begin
            rdata_o <= '0;
        end
    end

endmodule
